/* verification/hormr_host.sv */
// Host model: issues byte requests to the register bank.
// Assumes requests are taken on the rising edge of clock.
`timescale 1ns/10ps
module hormr_host (
  input wire logic clock,
  output hormr_pkg::hormr_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // Idle lines show the inverse, so a stale value is never trusted
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clock);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1 q = rdata;
  endtask
endmodule // hormr_host

/* verification/hormr_regs_tb.sv */
// Self-checking bench for the register bank.
// Assumes the host model drives every request.
`timescale 1ns/10ps
module hormr_regs_tb;
  logic clock = 0, reset_n = 0, cl = 0, zm = 0, zs = 0, cload = 0, rvalid, ph;
  logic [7:0] cval = 0, rdata, q;
  logic [7:0] mem [5];
  logic [9:0] per;
  logic [15:0] ptr, p;
  hormr_pkg::hormr_req_t req;
  hormr_pkg::hormr_drive_t drive;
  int n_mismatch = 0, n_tests = 0, cyc = 0, seed = 32'h4916e3ce, k, i;
  always #12.5 clock = ~clock;
  hormr_host u_hormr_host (.clock(clock), .req(req), .rdata(rdata));
  hormr_regs u_hormr_regs (.clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .closed_loop_drive(cl), .zero_crossing_miss(zm),
    .zero_crossing_seen(zs), .coef_load(cload), .coef_value(cval), .drive(drive),
    .openloop_period_value(per), .mem_pointer(ptr));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int attempts(input int f);
    return f + 3;
  endfunction
  task automatic chk(input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_hormr_host.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, e);
    u_hormr_host.acc(1'b0, a, 8'h00, q);
    chk(e, q);
    chk(1'b1, rvalid);
  endtask
  // Settles two edges so a registered fallback flag has landed
  task automatic miss(input int n);
    repeat (n) begin
      @(posedge clock);
      zm <= 1;
      @(posedge clock);
      zm <= 0;
    end
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1;
    repeat (4) @(posedge clock);
    chk(10'd198, per);
    rd(8'h2c, 8'h00);
    rd(8'h2e, 8'h00);
    rd(8'h2f, 8'hc6);
    rd(8'h30, 8'h00);
    rd(8'hfd, 8'h00);
    rd(8'hfe, 8'h00);
    rd(8'h5a, 8'h00);
    wr(8'h30, 8'h77);
    rd(8'h30, 8'h00);
    cval <= 8'($random(seed));
    cload <= 1;
    @(posedge clock);
    cload <= 0;
    rd(8'h30, cval);
    p = 16'($random(seed));
    wr(8'h2e, {6'h00, p[9:8]});
    wr(8'h2f, p[7:0]);
    chk(p[9:0], per);
    rd(8'h2e, {6'h00, p[9:8]});
    $display("register test done");
    for (k = 0; k < 2; k++) begin
      p = k ? 16'hfffe : 16'($random(seed));
      wr(8'hfd, p[15:8]);
      wr(8'hfe, p[7:0]);
      chk(p, ptr);
      for (i = 0; i < 5; i++) begin
        mem[i] = 8'($random(seed));
        wr(8'hff, mem[i]);
        chk(16'(p + i + 1), ptr);
      end
      wr(8'hfd, p[15:8]);
      wr(8'hfe, p[7:0]);
      for (i = 0; i < 5; i++) begin
        rd(8'hff, mem[i]);
        chk(16'(p + i + 1), ptr);
      end
    end
    $display("memory test done");
    cl <= 1;
    for (k = 0; k < 4; k++) begin
      zs <= 1;
      @(posedge clock);
      zs <= 0;
      wr(8'h2c, {1'b1, k[1:0], 5'h01});
      miss(attempts(k) - 1);
      chk(1'b0, drive.active);
      miss(1);
      chk(1'b1, drive.active);
      chk(1'b0, drive.sine);
      wr(8'h2c, 8'h01);
    end
    miss(8);
    chk(1'b0, drive.active);
    $display("fallback test done");
    cl <= 0;
    // High period bits still hold the random value from the register test
    wr(8'h2e, 8'h00);
    wr(8'h2f, 8'h02);
    chk(10'h002, per);
    chk(1'b1, drive.active);
    chk(1'b1, drive.sine);
    @(negedge clock);
    ph = drive.phase;
    while (drive.phase === ph) @(negedge clock);
    ph = drive.phase;
    i = 0;
    while (drive.phase === ph) begin
      @(negedge clock);
      i++;
    end
    chk(16'(2 * hormr_pkg::HORMR_STEP_CYCLES_I), 16'(i));
    $display("period test done");
    wrap_up();
  end
endmodule // hormr_regs_tb

/* verilog/hormr_pkg.sv */
// Constants and carrier types for the open-loop and memory-port register bank.
// Assumes a byte-wide register access port decoded upstream from the serial bus.
package hormr_pkg;
  localparam logic [7:0] HORMR_OFF_FALLBACK_CTRL = 8'h2c;
  localparam logic [7:0] HORMR_OFF_PERIOD_HIGH = 8'h2e;
  localparam logic [7:0] HORMR_OFF_PERIOD_LOW = 8'h2f;
  localparam logic [7:0] HORMR_OFF_IMPEDANCE_COEF = 8'h30;
  localparam logic [7:0] HORMR_OFF_PTR_HIGH = 8'hfd;
  localparam logic [7:0] HORMR_OFF_PTR_LOW = 8'hfe;
  localparam logic [7:0] HORMR_OFF_DATA_PORT = 8'hff;
  localparam int HORMR_BIT_AUTO_FALLBACK = 7;
  localparam int HORMR_BIT_COUNT_HI = 6;
  localparam int HORMR_BIT_COUNT_LO = 5;
  localparam int HORMR_BIT_WAVE_SELECT = 0;
  localparam logic [7:0] HORMR_RST_FALLBACK_CTRL = 8'h00;
  localparam logic [9:0] HORMR_RST_PERIOD = 10'h0c6;
  localparam logic [7:0] HORMR_RST_COEF = 8'h00;
  localparam logic [15:0] HORMR_RST_PTR = 16'h0000;
  localparam logic [2:0] HORMR_MIN_ATTEMPTS = 3'h3;
  // Time step in nanoseconds; printed as 24.39 us and 24.615 us, unresolved
  localparam int HORMR_STEP_NS = 24615;
  localparam int HORMR_CLOCK_NS = 25;
  localparam int HORMR_STEP_CYCLES_I = HORMR_STEP_NS / HORMR_CLOCK_NS;
  localparam logic [10:0] HORMR_STEP_CYCLES = 11'(HORMR_STEP_CYCLES_I);
  localparam int HORMR_MEM_AW = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hormr_req_t;

  typedef struct packed {
    logic active;
    logic sine;
    logic phase;
  } hormr_drive_t;
endpackage

/* verilog/hormr_regs.sv */
// Open-loop fallback control, period timer and indirect memory port.
// Requests are one-cycle strobes; read data is registered one cycle later.
`timescale 1ns/10ps
module hormr_regs (
  input wire logic clock,
  input wire logic reset_n,
  input wire hormr_pkg::hormr_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic closed_loop_drive,
  input wire logic zero_crossing_miss,
  input wire logic zero_crossing_seen,
  input wire logic coef_load,
  input wire logic [7:0] coef_value,
  output hormr_pkg::hormr_drive_t drive,
  output logic [9:0] openloop_period_value,
  output logic [15:0] mem_pointer
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q;
  logic [9:0] period_q;
  logic [7:0] coef_q;
  logic [15:0] ptr_q;
  logic [7:0] mem_q [0:(1 << hormr_pkg::HORMR_MEM_AW) - 1];
  logic wr_data, rd_data;
  assign wr_data = req.wr && req.addr == hormr_pkg::HORMR_OFF_DATA_PORT;
  assign rd_data = req.rd && !req.wr && req.addr == hormr_pkg::HORMR_OFF_DATA_PORT;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= hormr_pkg::HORMR_RST_FALLBACK_CTRL;
      period_q <= hormr_pkg::HORMR_RST_PERIOD;
    end else if (req.wr) begin
      // Control reserved bits stored as written (period high keeps only bits 1:0); host keeps them zero
      if (req.addr == hormr_pkg::HORMR_OFF_FALLBACK_CTRL) ctrl_q <= req.wdata;
      if (req.addr == hormr_pkg::HORMR_OFF_PERIOD_HIGH) period_q[9:8] <= req.wdata[1:0];
      if (req.addr == hormr_pkg::HORMR_OFF_PERIOD_LOW) period_q[7:0] <= req.wdata;
    end
  end

  // Coefficient is loaded only by the diagnostic engine; bus writes are ignored
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) coef_q <= hormr_pkg::HORMR_RST_COEF;
    else if (coef_load) coef_q <= coef_value;
  end

  // Pointer bytes written directly; data port accesses step it
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_q <= hormr_pkg::HORMR_RST_PTR;
    end else if (req.wr && req.addr == hormr_pkg::HORMR_OFF_PTR_HIGH) begin
      ptr_q[15:8] <= req.wdata;
    end else if (req.wr && req.addr == hormr_pkg::HORMR_OFF_PTR_LOW) begin
      ptr_q[7:0] <= req.wdata;
    end else if (wr_data || rd_data) begin
      ptr_q <= ptr_q + 16'h0001;
    end
  end

  // Memory has no reset so it maps to plain RAM
  always_ff @(posedge clock) begin
    if (wr_data) mem_q[ptr_q] <= req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd && !req.wr;
      if (req.rd && !req.wr) begin
        unique case (req.addr)
          hormr_pkg::HORMR_OFF_FALLBACK_CTRL: rdata <= ctrl_q;
          hormr_pkg::HORMR_OFF_PERIOD_HIGH: rdata <= {6'h00, period_q[9:8]};
          hormr_pkg::HORMR_OFF_PERIOD_LOW: rdata <= period_q[7:0];
          hormr_pkg::HORMR_OFF_IMPEDANCE_COEF: rdata <= coef_q;
          hormr_pkg::HORMR_OFF_PTR_HIGH: rdata <= ptr_q[15:8];
          hormr_pkg::HORMR_OFF_PTR_LOW: rdata <= ptr_q[7:0];
          hormr_pkg::HORMR_OFF_DATA_PORT: rdata <= mem_q[ptr_q];
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fallback engine
  logic auto_fallback_enable;
  logic [1:0] fallback_attempt_count;
  logic openloop_waveform_select;
  logic [2:0] limit;
  logic [2:0] miss_q;
  logic fell_back_q;
  assign auto_fallback_enable = ctrl_q[hormr_pkg::HORMR_BIT_AUTO_FALLBACK];
  assign fallback_attempt_count =
    ctrl_q[hormr_pkg::HORMR_BIT_COUNT_HI:hormr_pkg::HORMR_BIT_COUNT_LO];
  assign openloop_waveform_select = ctrl_q[hormr_pkg::HORMR_BIT_WAVE_SELECT];
  assign limit = hormr_pkg::HORMR_MIN_ATTEMPTS + {1'b0, fallback_attempt_count};

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      miss_q <= 3'h0;
      fell_back_q <= 1'b0;
    end else if (!closed_loop_drive || !auto_fallback_enable) begin
      // Fallback lasts only for the current closed-loop play
      miss_q <= 3'h0;
      fell_back_q <= 1'b0;
    end else if (zero_crossing_seen && !fell_back_q) begin
      miss_q <= 3'h0;
    end else if (zero_crossing_miss && !fell_back_q) begin
      miss_q <= miss_q + 3'h1;
      if (miss_q + 3'h1 >= limit) fell_back_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-period timer: toggle phase every period_q steps
  logic [10:0] step_q;
  logic [9:0] units_q;
  logic phase_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      step_q <= 11'h000;
      units_q <= 10'h000;
      phase_q <= 1'b0;
    end else if (!drive.active) begin
      step_q <= 11'h000;
      units_q <= 10'h000;
      phase_q <= 1'b0;
    end else if (step_q == hormr_pkg::HORMR_STEP_CYCLES - 11'h001) begin
      step_q <= 11'h000;
      if (units_q + 10'h001 >= period_q) begin
        units_q <= 10'h000;
        phase_q <= ~phase_q;
      end else begin
        units_q <= units_q + 10'h001;
      end
    end else begin
      step_q <= step_q + 11'h001;
    end
  end

  assign drive.active = fell_back_q || (!closed_loop_drive);
  assign drive.sine = fell_back_q ? 1'b0 : openloop_waveform_select;
  assign drive.phase = phase_q;
  assign openloop_period_value = period_q;
  assign mem_pointer = ptr_q;

  ////////////////////////////////////////////////////////////////////////////
  fallback_square_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    fell_back_q |-> !drive.sine) else $error("fallback not square");
  wave_select_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    (!fell_back_q && !closed_loop_drive) |-> drive.sine == ctrl_q[0])
    else $error("wave select ignored");
  no_auto_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    !auto_fallback_enable |=> !fell_back_q) else $error("fallback while off");
  attempt_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    $rose(fell_back_q) |-> $past(miss_q) + 3'h1 == limit)
    else $error("wrong attempt count");
  period_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    req.wr && req.addr == hormr_pkg::HORMR_OFF_PERIOD_LOW |=> period_q[7:0] == $past(req.wdata))
    else $error("period low not stored");
  coef_ro_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    !coef_load |=> coef_q == $past(coef_q)) else $error("coefficient changed");
  ptr_load_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    req.wr && req.addr == hormr_pkg::HORMR_OFF_PTR_HIGH |=> ptr_q[15:8] == $past(req.wdata))
    else $error("pointer high not stored");
  sequence data_access_s;
    wr_data || rd_data;
  endsequence
  ptr_step_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    data_access_s |=> ptr_q == $past(ptr_q) + 16'h0001) else $error("pointer not stepped");
  mem_write_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    wr_data |=> mem_q[$past(ptr_q)] == $past(req.wdata)) else $error("byte not stored");
  read_back_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    rd_data |=> rvalid && rdata == mem_q[$past(ptr_q)]) else $error("bad read data");
  half_period_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    $changed(phase_q) && drive.active |-> step_q == 11'h000) else $error("phase off step");
endmodule // hormr_regs
